// ### addr_map_defs.vh
// Constants for the system address decoder: region bounds, target
// select bits, master numbers and fault cause codes.
// Assumes 32-bit byte addresses shared by every bus master.
`ifndef ADDR_MAP_DEFS_VH
`define ADDR_MAP_DEFS_VH

// ************************************************************
// Architectural regions
// ************************************************************
`define CODE_LO       32'h0000_0000
`define CODE_HI       32'h1fff_ffff
`define DATA_LO       32'h2000_0000
`define DATA_HI       32'h3fff_ffff
`define PERIPH_LO     32'h4000_0000
`define PERIPH_HI     32'h5fff_ffff
`define SERMEM_LO     32'h6000_0000
`define SERMEM_HI     32'h9fff_ffff
`define UNUSED_LO     32'ha000_0000
`define UNUSED_HI     32'hdfff_ffff
`define PRIVBUS_LO    32'he000_0000
`define PRIVBUS_HI    32'he00f_ffff
`define SYSREG_LO     32'he010_0000
`define SYSREG_HI     32'hffff_ffff

// ************************************************************
// Internal memories inside the code region
// ************************************************************
`define ROM_LO        32'h0000_0000
`define ROM_HI        32'h0000_ffff
`define SRAM_LO       32'h0800_0000
`define SRAM_HI       32'h0803_ffff
`define APPFL_LO      32'h1000_0000
`define APPFL_HI      32'h1007_ffff
`define AUXFL_LO      32'h1400_0000
`define AUXFL_HI      32'h1400_7fff
`define SUPFL_LO      32'h1600_0000
`define SUPFL_HI      32'h1600_7fff

// ************************************************************
// Target select bit positions
// ************************************************************
`define TGT_W         9
`define TGT_ROM       0
`define TGT_SRAM      1
`define TGT_APPFL     2
`define TGT_AUXFL     3
`define TGT_SUPFL     4
`define TGT_PERIPH    5
`define TGT_SERMEM    6
`define TGT_PRIVBUS   7
`define TGT_SYSREG    8

// ************************************************************
// Masters, contexts and fault causes
// ************************************************************
`define MST_PRI       2'h0
`define MST_SEC       2'h1
`define MST_DBG       2'h2
`define ROM_EXEC_CTX  3'h0
`define CAUSE_NONE    2'h0
`define CAUSE_UNMAP   2'h1
`define CAUSE_XPERIPH 2'h2
`define CAUSE_XROM    2'h3

`endif

// ### addr_region_decode.v
// Combinational decode of one master's address into a target select
// and a fault cause.
// Assumes the caller registers the result; master number is a port.
`timescale 1ns/1ps
`include "addr_map_defs.vh"

module addr_region_decode
(
   input  wire [31:0] addr_i,   // Request address
   input  wire        fetch_i,  // High for instruction fetch
   input  wire [1:0]  master_i, // Requesting master number
   input  wire [2:0]  ctx_i,    // Protection context
   output reg  [8:0]  sel_o,    // One-hot target select
   output reg  [1:0]  cause_o   // Fault cause, zero when routed
);

   // Inclusive range check used by every region except the system registers, which take the final else
   function in_rng;
      input [31:0] a;
      input [31:0] lo;
      input [31:0] hi;
      begin
         in_rng = (a >= lo) && (a <= hi);
      end
   endfunction

   // ************************************************************
   // Region decode
   // ************************************************************
   // Address passes unchanged; no single-bit alias translation
   always @*
   begin
      sel_o   = 9'h000;
      cause_o = `CAUSE_NONE;
      if (in_rng(addr_i, `ROM_LO, `ROM_HI))
      begin
         if (fetch_i && !((master_i == `MST_SEC) && (ctx_i == `ROM_EXEC_CTX)))
            cause_o = `CAUSE_XROM;
         else
            sel_o[`TGT_ROM] = 1'b1;
      end
      else if (in_rng(addr_i, `SRAM_LO, `SRAM_HI))
         sel_o[`TGT_SRAM] = 1'b1;
      else if (in_rng(addr_i, `APPFL_LO, `APPFL_HI))
         sel_o[`TGT_APPFL] = 1'b1;
      else if (in_rng(addr_i, `AUXFL_LO, `AUXFL_HI))
         sel_o[`TGT_AUXFL] = 1'b1;
      else if (in_rng(addr_i, `SUPFL_LO, `SUPFL_HI))
         sel_o[`TGT_SUPFL] = 1'b1;
      else if (in_rng(addr_i, `CODE_LO, `CODE_HI))
         cause_o = `CAUSE_UNMAP;
      else if (in_rng(addr_i, `DATA_LO, `DATA_HI))
         cause_o = `CAUSE_UNMAP;
      else if (in_rng(addr_i, `PERIPH_LO, `PERIPH_HI))
      begin
         if (fetch_i)
            cause_o = `CAUSE_XPERIPH;
         else
            sel_o[`TGT_PERIPH] = 1'b1;
      end
      else if (in_rng(addr_i, `SERMEM_LO, `SERMEM_HI))
         sel_o[`TGT_SERMEM] = 1'b1;
      else if (in_rng(addr_i, `UNUSED_LO, `UNUSED_HI))
         cause_o = `CAUSE_UNMAP;
      else if (in_rng(addr_i, `PRIVBUS_LO, `PRIVBUS_HI))
         sel_o[`TGT_PRIVBUS] = 1'b1;
      else
         sel_o[`TGT_SYSREG] = 1'b1;
   end

endmodule

// ### fault_capture.v
// Holds the first decode fault until cleared, plus an overflow flag.
// Assumes fault strobes are one-cycle pulses on the system clock.
`timescale 1ns/1ps
`include "addr_map_defs.vh"

module fault_capture
(
   input  wire        clk_i,    // System clock
   input  wire        rst_i,    // Synchronous reset, active high
   input  wire        hit_i,    // Fault strobe
   input  wire [31:0] addr_i,   // Faulting address
   input  wire [1:0]  master_i, // Faulting master
   input  wire [1:0]  cause_i,  // Fault cause
   input  wire        clr_i,    // Clear pulse
   output reg         vld_o,    // Fault held
   output reg  [31:0] addr_o,   // Held address
   output reg  [1:0]  master_o, // Held master
   output reg  [1:0]  cause_o,  // Held cause
   output reg         ovf_o     // Further fault while held
);

   // ************************************************************
   // Capture; a new fault wins over a clear in the same cycle
   // ************************************************************
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         vld_o    <= 1'b0;
         addr_o   <= 32'h0000_0000;
         master_o <= 2'h0;
         cause_o  <= `CAUSE_NONE;
         ovf_o    <= 1'b0;
      end
      else
      begin
         if (hit_i && (!vld_o || clr_i))
         begin
            vld_o    <= 1'b1;
            addr_o   <= addr_i;
            master_o <= master_i;
            cause_o  <= cause_i;
         end
         else if (clr_i)
            vld_o <= 1'b0;
         if (hit_i && vld_o && !clr_i)
            ovf_o <= 1'b1;
         else if (clr_i)
            ovf_o <= 1'b0;
      end
   end

endmodule

// ### system_address_decoder.v
// System address decoder: routes requests of the primary CPU, the
// secondary CPU and the debug access port to one of nine targets.
// Assumes all requesters run on MCLK_I; a request is a one-cycle
// strobe and the answer follows on the next edge.
//
// Notes on behaviour
// - 0x00000000-0x1fffffff is the code region, open to fetches and data.
// - Address zero lands at the start of the boot ROM for vector fetch.
// - 0x20000000-0x3fffffff has no memory behind it.
// - 0x40000000-0x5fffffff reaches peripherals and fetches there fail.
// - Peripheral addresses pass untranslated, with no bit aliasing.
// - 0x60000000-0x9fffffff goes to the serial memory window, any kind.
// - 0xa0000000-0xdfffffff selects no target.
// - 0xe0000000-0xe00fffff goes to the core-private bus.
// - 0xe0100000-0xffffffff goes to system registers.
// - 0x00000000-0x0000ffff selects the 64 KB boot ROM.
// - 0x08000000-0x0803ffff selects up to 256 KB of SRAM.
// - 0x10000000-0x1007ffff selects up to 512 KB of application flash.
// - 0x14000000-0x14007fff selects the 32 KB auxiliary flash.
// - 0x16000000-0x16007fff selects the 32 KB supervisory flash.
// - Every master sees the same map through the same decoder.
// - ROM fetches are allowed only to the secondary CPU in context 0.
`timescale 1ns/1ps
`include "addr_map_defs.vh"

module system_address_decoder
(
   input  wire        MCLK_I,         // System bus clock, 25 MHz
   input  wire        SYS_RST_I,      // Synchronous reset, active high
   // Primary CPU
   input  wire        PRI_REQ_I,      // Request strobe
   input  wire [31:0] PRI_ADDR_I,     // Request address
   input  wire        PRI_FETCH_I,    // Instruction fetch
   input  wire [2:0]  PRI_CTX_I,      // Protection context
   output wire        PRI_RSP_O,      // Answer strobe
   output wire        PRI_ERR_O,      // Bus error with answer
   output wire [8:0]  PRI_SEL_O,      // Target select
   output wire [31:0] PRI_TADDR_O,    // Address to target
   // Secondary CPU
   input  wire        SEC_REQ_I,      // Request strobe
   input  wire [31:0] SEC_ADDR_I,     // Request address
   input  wire        SEC_FETCH_I,    // Instruction fetch
   input  wire [2:0]  SEC_CTX_I,      // Protection context
   output wire        SEC_RSP_O,      // Answer strobe
   output wire        SEC_ERR_O,      // Bus error with answer
   output wire [8:0]  SEC_SEL_O,      // Target select
   output wire [31:0] SEC_TADDR_O,    // Address to target
   // Debug access port
   input  wire        DBG_REQ_I,      // Request strobe
   input  wire [31:0] DBG_ADDR_I,     // Request address
   input  wire        DBG_FETCH_I,    // Instruction fetch
   input  wire [2:0]  DBG_CTX_I,      // Protection context
   output wire        DBG_RSP_O,      // Answer strobe
   output wire        DBG_ERR_O,      // Bus error with answer
   output wire [8:0]  DBG_SEL_O,      // Target select
   output wire [31:0] DBG_TADDR_O,    // Address to target
   // Fault record
   input  wire        FAULT_CLR_I,    // Clear held fault
   output wire        FAULT_VLD_O,    // Fault held
   output wire [31:0] FAULT_ADDR_O,   // Held fault address
   output wire [1:0]  FAULT_MASTER_O, // Held fault master
   output wire [1:0]  FAULT_CAUSE_O,  // Held fault cause
   output wire        FAULT_OVF_O     // Fault lost while held
);

   localparam NMST = 3;

   // ************************************************************
   // Request gathering
   // ************************************************************
   // Packed views of the three requesters, index = master number
   wire [NMST-1:0]    req;
   wire [NMST*32-1:0] addr;
   wire [NMST-1:0]    fetch;
   wire [NMST*3-1:0]  ctx;
   wire [NMST*9-1:0]  sel;
   wire [NMST*2-1:0]  cause;

   assign req   = {DBG_REQ_I, SEC_REQ_I, PRI_REQ_I};
   assign addr  = {DBG_ADDR_I, SEC_ADDR_I, PRI_ADDR_I};
   assign fetch = {DBG_FETCH_I, SEC_FETCH_I, PRI_FETCH_I};
   assign ctx   = {DBG_CTX_I, SEC_CTX_I, PRI_CTX_I};

   // Answer registers for every master
   reg  [NMST-1:0]    rsp_ff;
   reg  [NMST-1:0]    err_ff;
   reg  [NMST*9-1:0]  sel_ff;
   reg  [NMST*32-1:0] taddr_ff;

   // ************************************************************
   // Per-master decode and answer stage
   // ************************************************************
   genvar m;
   generate
      for (m = 0; m < NMST; m = m + 1)
      begin : g_mst
         // Master number as a sized constant for the decoder pin
         localparam [31:0] MIDX = m;

         // Same decoder for every master gives one shared map
         addr_region_decode u_dec
         (
            .addr_i   (addr[m*32 +: 32]),
            .fetch_i  (fetch[m]),
            .master_i (MIDX[1:0]),
            .ctx_i    (ctx[m*3 +: 3]),
            .sel_o    (sel[m*9 +: 9]),
            .cause_o  (cause[m*2 +: 2])
         );

         // Answer one edge after the request; error replaces routing
         always @(posedge MCLK_I)
         begin
            if (SYS_RST_I)
            begin
               rsp_ff[m]           <= 1'b0;
               err_ff[m]           <= 1'b0;
               sel_ff[m*9 +: 9]    <= 9'h000;
               taddr_ff[m*32 +: 32] <= 32'h0000_0000;
            end
            else
            begin
               rsp_ff[m] <= req[m];
               err_ff[m] <= req[m] && (cause[m*2 +: 2] != `CAUSE_NONE);
               if (req[m])
               begin
                  sel_ff[m*9 +: 9]     <= sel[m*9 +: 9];
                  taddr_ff[m*32 +: 32] <= addr[m*32 +: 32];
               end
               else
                  sel_ff[m*9 +: 9] <= 9'h000;
            end
         end
      end
   endgenerate

   // ************************************************************
   // Fault selection: lowest master number wins
   // ************************************************************
   reg        f_hit;
   reg [31:0] f_addr;
   reg [1:0]  f_mst;
   reg [1:0]  f_cause;
   integer    k;

   always @*
   begin
      f_hit   = 1'b0;
      f_addr  = 32'h0000_0000;
      f_mst   = 2'h0;
      f_cause = `CAUSE_NONE;
      for (k = NMST - 1; k >= 0; k = k - 1)
      begin
         if (req[k] && (cause[k*2 +: 2] != `CAUSE_NONE))
         begin
            f_hit   = 1'b1;
            f_addr  = addr[k*32 +: 32];
            f_mst   = k[1:0];
            f_cause = cause[k*2 +: 2];
         end
      end
   end

   fault_capture u_fault
   (
      .clk_i    (MCLK_I),
      .rst_i    (SYS_RST_I),
      .hit_i    (f_hit),
      .addr_i   (f_addr),
      .master_i (f_mst),
      .cause_i  (f_cause),
      .clr_i    (FAULT_CLR_I),
      .vld_o    (FAULT_VLD_O),
      .addr_o   (FAULT_ADDR_O),
      .master_o (FAULT_MASTER_O),
      .cause_o  (FAULT_CAUSE_O),
      .ovf_o    (FAULT_OVF_O)
   );

   // ************************************************************
   // Output wiring, all straight from answer registers
   // ************************************************************
   assign PRI_RSP_O   = rsp_ff[0];
   assign PRI_ERR_O   = err_ff[0];
   assign PRI_SEL_O   = sel_ff[8:0];
   assign PRI_TADDR_O = taddr_ff[31:0];

   assign SEC_RSP_O   = rsp_ff[1];
   assign SEC_ERR_O   = err_ff[1];
   assign SEC_SEL_O   = sel_ff[17:9];
   assign SEC_TADDR_O = taddr_ff[63:32];

   assign DBG_RSP_O   = rsp_ff[2];
   assign DBG_ERR_O   = err_ff[2];
   assign DBG_SEL_O   = sel_ff[26:18];
   assign DBG_TADDR_O = taddr_ff[95:64];

endmodule

// ### cpu_bus_master.sv
// Model of one bus master that issues single requests to the decoder.
// Assumes a one-cycle answer and drives just after the rising edge.
`timescale 1ns/1ps

module cpu_bus_master
(
   input  wire         clk_i,   // System clock
   output logic        req_o,   // Request strobe
   output logic [31:0] addr_o,  // Request address
   output logic        fetch_o, // Instruction fetch
   output logic [2:0]  ctx_o,   // Protection context
   input  wire         rsp_i,   // Answer strobe
   input  wire         err_i,   // Bus error
   input  wire  [8:0]  sel_i,   // Target select
   input  wire  [31:0] taddr_i  // Address to target
);
   // Idle lines at time zero
   initial
   begin
      req_o = 1'b0;
      addr_o = 32'h0000_0000;
      fetch_o = 1'b0;
      ctx_o = 3'h0;
   end

   // One request for one cycle, answer taken one edge later
   task automatic xfer(input [31:0] a, input f, input [2:0] c, output r, output e,
                       output [8:0] s, output [31:0] ta);
      @(posedge clk_i);
      #1;
      req_o = 1'b1;
      addr_o = a;
      fetch_o = f;
      ctx_o = c;
      @(posedge clk_i);
      #1;
      r = rsp_i;
      e = err_i;
      s = sel_i;
      ta = taddr_i;
      req_o = 1'b0;
      // Released lines must not keep the old value
      addr_o = ~a;
      fetch_o = ~f;
      ctx_o = ~c;
   endtask
endmodule

// ### system_address_decoder_monitor.sv
// Checker of the decoder's answer ports for two masters.
// Assumes it is bound onto system_address_decoder; one clock domain.
`timescale 1ns/1ps

module system_address_decoder_monitor
(
   input wire        MCLK_I,      // Clock
   input wire        SYS_RST_I,   // Reset
   input wire        PRI_REQ_I,   // Request
   input wire [31:0] PRI_ADDR_I,  // Address
   input wire        PRI_FETCH_I, // Fetch
   input wire        PRI_RSP_O,   // Answer
   input wire        PRI_ERR_O,   // Error
   input wire [8:0]  PRI_SEL_O,   // Select
   input wire [31:0] PRI_TADDR_O, // Target address
   input wire        SEC_REQ_I,   // Request
   input wire [31:0] SEC_ADDR_I,  // Address
   input wire        SEC_FETCH_I, // Fetch
   input wire [2:0]  SEC_CTX_I,   // Context
   input wire [8:0]  SEC_SEL_O,   // Select
   input wire        FAULT_VLD_O  // Fault held
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   // Data request and top address bits of the primary CPU
   wire       pd = PRI_REQ_I && !PRI_FETCH_I;
   wire [2:0] rg = PRI_ADDR_I[31:29];

   AST_RSP_NEXT: assert property (PRI_REQ_I |=> PRI_RSP_O)
      else $error("no answer one cycle after request");
   AST_RSP_ONLY: assert property (!PRI_REQ_I |=> !PRI_RSP_O)
      else $error("answer without request");
   AST_ERR_NOSEL: assert property (PRI_ERR_O |-> PRI_RSP_O && PRI_SEL_O == 9'h000)
      else $error("error answer selected a target");
   AST_ROM_DATA: assert property (pd && PRI_ADDR_I <= 32'h0000_ffff
      |=> PRI_SEL_O == 9'h001) else $error("boot memory data read not routed");
   AST_DATA_HOLE: assert property (PRI_REQ_I && rg == 3'h1 |=> PRI_ERR_O)
      else $error("data region access not refused");
   AST_PERI_FETCH: assert property (PRI_REQ_I && PRI_FETCH_I && rg == 3'h2
      |=> PRI_ERR_O) else $error("peripheral fetch not refused");
   AST_PERI_PASS: assert property (pd && rg == 3'h2 |=> PRI_SEL_O == 9'h020
      && PRI_TADDR_O == $past(PRI_ADDR_I)) else $error("peripheral address altered");
   AST_SERMEM: assert property (PRI_REQ_I && rg inside {3'h3, 3'h4}
      |=> PRI_SEL_O == 9'h040) else $error("serial window not selected");
   AST_UNUSED: assert property (PRI_REQ_I && rg inside {3'h5, 3'h6}
      |=> PRI_ERR_O) else $error("unused range not refused");
   AST_PRI_ROMX: assert property (PRI_REQ_I && PRI_FETCH_I
      && PRI_ADDR_I <= 32'h0000_ffff |=> PRI_ERR_O) else $error("primary boot fetch allowed");
   AST_SEC_ROMX: assert property (SEC_REQ_I && SEC_FETCH_I && SEC_ADDR_I <= 32'h0000_ffff
      |=> (SEC_SEL_O == 9'h001) == ($past(SEC_CTX_I) == 3'h0)) else $error("context check wrong");
   AST_FAULT: assert property (PRI_ERR_O |-> FAULT_VLD_O)
      else $error("error answer left no fault record");
endmodule

bind system_address_decoder system_address_decoder_monitor mon_inst (.MCLK_I(MCLK_I),
   .SYS_RST_I(SYS_RST_I), .PRI_REQ_I(PRI_REQ_I), .PRI_ADDR_I(PRI_ADDR_I),
   .PRI_FETCH_I(PRI_FETCH_I), .PRI_RSP_O(PRI_RSP_O), .PRI_ERR_O(PRI_ERR_O),
   .PRI_SEL_O(PRI_SEL_O), .PRI_TADDR_O(PRI_TADDR_O), .SEC_REQ_I(SEC_REQ_I),
   .SEC_ADDR_I(SEC_ADDR_I), .SEC_FETCH_I(SEC_FETCH_I), .SEC_CTX_I(SEC_CTX_I),
   .SEC_SEL_O(SEC_SEL_O), .FAULT_VLD_O(FAULT_VLD_O));

// ### system_address_decoder_tb.sv
// Self-checking bench for the system address decoder.
// Assumes three bus master models and a 25 MHz clock.
`timescale 1ns/1ps
`include "addr_map_defs.vh"

module system_address_decoder_tb;
   logic mclk, rst, clr, r, cr[3], ce[3];
   logic [8:0] cs[3];
   logic [31:0] ct[3];
   int num_errors = 0, total_checks = 0, cycles = 0, j, k;
   wire [2:0] req, fetch, rsp, err;
   wire [31:0] addr[3], taddr[3];
   wire [2:0] ctx[3];
   wire [8:0] sel[3];
   wire fvld, fovf;
   wire [31:0] faddr;
   wire [1:0] fmst, fcause;
   logic [31:0] corner[27] = '{32'h0, 32'hffff, 32'h10000, 32'h07ff_ffff, `SRAM_LO,
      `SRAM_HI, 32'h0804_0000, `APPFL_LO, `APPFL_HI, `AUXFL_LO, `AUXFL_HI, `SUPFL_LO,
      `SUPFL_HI, 32'h1600_8000, `CODE_HI, `DATA_LO, `DATA_HI, `PERIPH_LO, `PERIPH_HI,
      `SERMEM_LO, `SERMEM_HI, `UNUSED_LO, `UNUSED_HI, `PRIVBUS_LO, `PRIVBUS_HI,
      `SYSREG_LO, `SYSREG_HI};

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // *****************************
   // Masters and decoder
   // *****************************
   for (genvar i = 0; i < 3; i++)
   begin : m
      cpu_bus_master mst (.clk_i(mclk), .req_o(req[i]), .addr_o(addr[i]), .fetch_o(fetch[i]),
         .ctx_o(ctx[i]), .rsp_i(rsp[i]), .err_i(err[i]), .sel_i(sel[i]), .taddr_i(taddr[i]));
   end
   system_address_decoder system_address_decoder_inst (.MCLK_I(mclk), .SYS_RST_I(rst),
      .PRI_REQ_I(req[0]), .PRI_ADDR_I(addr[0]), .PRI_FETCH_I(fetch[0]), .PRI_CTX_I(ctx[0]),
      .PRI_RSP_O(rsp[0]), .PRI_ERR_O(err[0]), .PRI_SEL_O(sel[0]), .PRI_TADDR_O(taddr[0]),
      .SEC_REQ_I(req[1]), .SEC_ADDR_I(addr[1]), .SEC_FETCH_I(fetch[1]), .SEC_CTX_I(ctx[1]),
      .SEC_RSP_O(rsp[1]), .SEC_ERR_O(err[1]), .SEC_SEL_O(sel[1]), .SEC_TADDR_O(taddr[1]),
      .DBG_REQ_I(req[2]), .DBG_ADDR_I(addr[2]), .DBG_FETCH_I(fetch[2]), .DBG_CTX_I(ctx[2]),
      .DBG_RSP_O(rsp[2]), .DBG_ERR_O(err[2]), .DBG_SEL_O(sel[2]), .DBG_TADDR_O(taddr[2]),
      .FAULT_CLR_I(clr), .FAULT_VLD_O(fvld), .FAULT_ADDR_O(faddr), .FAULT_MASTER_O(fmst),
      .FAULT_CAUSE_O(fcause), .FAULT_OVF_O(fovf));

   // Expected error bit and one-hot select of one request
   function automatic [9:0] expect_rsp(input [31:0] a, input f, input [1:0] mm, input [2:0] c);
      int t;
      begin
         t = -1;
         if (a <= `ROM_HI) t = (f && !(mm == `MST_SEC && c == `ROM_EXEC_CTX)) ? -1 : `TGT_ROM;
         else if (a >= `SRAM_LO && a <= `SRAM_HI) t = `TGT_SRAM;
         else if (a >= `APPFL_LO && a <= `APPFL_HI) t = `TGT_APPFL;
         else if (a >= `AUXFL_LO && a <= `AUXFL_HI) t = `TGT_AUXFL;
         else if (a >= `SUPFL_LO && a <= `SUPFL_HI) t = `TGT_SUPFL;
         else if (a >= `PERIPH_LO && a <= `PERIPH_HI) t = f ? -1 : `TGT_PERIPH;
         else if (a >= `SERMEM_LO && a <= `SERMEM_HI) t = `TGT_SERMEM;
         else if (a >= `PRIVBUS_LO && a <= `PRIVBUS_HI) t = `TGT_PRIVBUS;
         else if (a >= `SYSREG_LO) t = `TGT_SYSREG;
         expect_rsp = (t < 0) ? 10'h200 : {1'b0, 9'h001 << t};
      end
   endfunction

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, want, seen);
      end
   endtask

   // One request through the chosen master, all answer fields compared
   task automatic run_one(input [1:0] mm, input [31:0] a, input f, input [2:0] c);
      logic rr, e;
      logic [8:0] s;
      logic [31:0] ta;
      logic [9:0] x;
      x = expect_rsp(a, f, mm, c);
      case (mm)
         2'h0: m[0].mst.xfer(a, f, c, rr, e, s, ta);
         2'h1: m[1].mst.xfer(a, f, c, rr, e, s, ta);
         default: m[2].mst.xfer(a, f, c, rr, e, s, ta);
      endcase
      chk("rsp", rr, 1'b1);
      chk("err", e, x[9]);
      chk("sel", s, x[8:0]);
      chk("taddr", ta, a);
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Cuts a hung run short
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   initial
   begin
      r = 1'($urandom(45282));
      clr = 1'b0;
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 rst = 1'b0;
      // Region bounds for every master, data and fetch
      foreach (corner[q]) for (j = 0; j < 6; j++) run_one(2'(j % 3), corner[q], 1'(j / 3), 3'h0);
      $display("test region bounds done");
      // Boot memory fetch from address zero in every context
      for (j = 0; j < 8; j++) for (k = 0; k < 3; k++) run_one(2'(k), 32'h0, 1'b1, 3'(j));
      $display("test boot fetch done");
      repeat (300) run_one(2'($urandom % 3), $urandom, 1'($urandom), 3'($urandom));
      $display("test random done");
      // Fault record cleared, then three peripheral fetches at once
      @(posedge mclk);
      #1 clr = 1'b1;
      @(posedge mclk);
      #1 clr = 1'b0;
      chk("fault cleared", fvld, 1'b0);
      fork
         m[0].mst.xfer(`PERIPH_LO, 1'b1, 3'h0, cr[0], ce[0], cs[0], ct[0]);
         m[1].mst.xfer(`PERIPH_LO, 1'b1, 3'h0, cr[1], ce[1], cs[1], ct[1]);
         m[2].mst.xfer(`PERIPH_LO, 1'b1, 3'h0, cr[2], ce[2], cs[2], ct[2]);
      join
      for (j = 0; j < 3; j++) chk("err together", {cr[j], ce[j], cs[j]}, 11'h600);
      chk("fault held", fvld, 1'b1);
      chk("fault master", fmst, `MST_PRI);
      chk("fault cause", fcause, `CAUSE_XPERIPH);
      chk("fault addr", faddr, `PERIPH_LO);
      chk("fault ovf clear", fovf, 1'b0);
      $display("test concurrent fault done");
      // A second fault while one is held is lost and flagged
      run_one(2'h1, `DATA_HI, 1'b0, 3'h0);
      chk("fault ovf set", fovf, 1'b1);
      chk("fault addr kept", faddr, `PERIPH_LO);
      chk("fault master kept", fmst, `MST_PRI);
      // Clear and a new fault on the same edge: the fault is kept
      fork
         begin
            @(posedge mclk);
            #1 clr = 1'b1;
            @(posedge mclk);
            #1 clr = 1'b0;
         end
         run_one(2'h2, 32'h0000_0100, 1'b1, 3'h0);
      join
      chk("fault set wins", fvld, 1'b1);
      chk("fault master dbg", fmst, `MST_DBG);
      chk("fault cause rom", fcause, `CAUSE_XROM);
      chk("fault addr rom", faddr, 32'h0000_0100);
      chk("fault ovf after clr", fovf, 1'b0);
      $display("test fault record done");
      give_verdict();
   end
endmodule
